// ---- logic/tcfm_monitor.sv ----
// Fault detection, latching and indication core with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "tcfm_regs.svh"
module tcfm_monitor #(
    parameter int CHANNELS = 18,
    parameter int TICK_CYCLES = `TCFM_TICK_PERIOD_NS / `TCFM_CLK_PERIOD_NS,
    parameter tcfm_pkg::tcfm_ms_t BO_OFF_MS = `TCFM_BO_OFF_MS_DFLT
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic [11:0] PADDR_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic [CHANNELS-1:0] RED_I,
    input wire logic [CHANNELS-1:0] YEL_I,
    input wire logic [CHANNELS-1:0] GRN_I,
    input wire logic RED_FAIL_INHIBIT1_I,
    input wire logic RED_FAIL_INHIBIT2_I,
    input wire logic RED_PERMIT_I,
    input wire logic RELAY_COMMON_INPUT_I,
    input wire logic RED_INTERFACE_CABLE_I,
    input wire logic AC_OK_I,
    input wire logic WATCHDOG_I,
    input wire logic PANEL_RESET_I,
    input wire logic REMOTE_RESET_I,
    output logic [CHANNELS-1:0] LED_RED_O,
    output logic [CHANNELS-1:0] LED_YEL_O,
    output logic [CHANNELS-1:0] LED_GRN_O,
    output logic TRIGGERED_O,
    output logic FLASH_O
);
    localparam int NQ = 3 * CHANNELS + 2;
    localparam int NP = NQ + 7;
    localparam int TW = $clog2(TICK_CYCLES);
    // Cable and AC sense idle high, so release from reset raises no false fault
    localparam logic [NP-1:0] PIN_IDLE = {3'b000, 2'b11, {(NQ + 2){1'b0}}};

    // Advance a millisecond count on the tick, saturating at its limit
    function automatic tcfm_pkg::tcfm_ms_t sat_tick(input tcfm_pkg::tcfm_ms_t cnt,
                                                    input tcfm_pkg::tcfm_ms_t lim,
                                                    input logic tk);
        sat_tick = (tk && cnt < lim) ? cnt + 12'h001 : cnt;
    endfunction

    // Synchronisers; stage one feeds only stage two
    logic [NP-1:0] pin_meta;
    logic [NP-1:0] pin_s;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            pin_meta <= PIN_IDLE;
            pin_s <= PIN_IDLE;
        end
        else
        begin
            pin_meta <= {REMOTE_RESET_I, PANEL_RESET_I, WATCHDOG_I, AC_OK_I,
                         RED_INTERFACE_CABLE_I, RELAY_COMMON_INPUT_I, RED_PERMIT_I,
                         RED_FAIL_INHIBIT2_I, RED_FAIL_INHIBIT1_I, GRN_I, YEL_I, RED_I};
            pin_s <= pin_meta;
        end
    end

    logic red_en_s;
    logic rc_level_s;
    logic cable_s;
    logic ac_ok_s;
    logic wdt_s;
    logic ext_reset_s;
    assign red_en_s = pin_s[NQ];
    assign rc_level_s = pin_s[NQ+1];
    assign cable_s = pin_s[NQ+2];
    assign ac_ok_s = pin_s[NQ+3];
    assign wdt_s = pin_s[NQ+4];
    assign ext_reset_s = pin_s[NQ+5] | pin_s[NQ+6];

    // Millisecond tick
    logic [TW-1:0] tick_cnt;
    logic tick;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (tick_cnt == TW'(TICK_CYCLES - 1));
            tick_cnt <= (tick_cnt == TW'(TICK_CYCLES - 1)) ? '0 : tick_cnt + 1'b1;
        end
    end

    // Registers
    logic [4:0] ctrl;
    logic [CHANNELS-1:0] rf_en;
    logic [CHANNELS-1:0] clr_en;
    logic cmd_reset;
    logic apb_wr;
    assign apb_wr = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

    // Duration qualification of field and inhibit inputs
    tcfm_pkg::tcfm_ms_t qcnt [NQ];
    logic [NQ-1:0] q;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            for (int i = 0; i < NQ; i++)
                qcnt[i] <= '0;
            q <= '0;
        end
        else
        begin
            for (int i = 0; i < NQ; i++)
            begin
                if (!pin_s[i])
                begin
                    // Low input is below the off level: drops at once
                    qcnt[i] <= '0;
                    q[i] <= 1'b0;
                end
                else if (i < 3 * CHANNELS)
                begin
                    qcnt[i] <= sat_tick(qcnt[i], `TCFM_FIELD_ON_MS, tick);
                    q[i] <= (qcnt[i] >= `TCFM_FIELD_ON_MS);
                end
                else
                begin
                    qcnt[i] <= sat_tick(qcnt[i], `TCFM_INHIBIT_ON_MS, tick);
                    q[i] <= (qcnt[i] >= `TCFM_INHIBIT_ON_MS);
                end
            end
        end
    end

    logic [CHANNELS-1:0] red_q;
    logic [CHANNELS-1:0] yel_q;
    logic [CHANNELS-1:0] grn_q;
    logic inhibit;
    logic rc_active;
    assign red_q = q[CHANNELS-1:0];
    assign yel_q = q[2*CHANNELS-1:CHANNELS];
    assign grn_q = q[3*CHANNELS-1:2*CHANNELS];
    assign inhibit = q[NQ-2] | q[NQ-1];
    assign rc_active = rc_level_s ^ ctrl[`TCFM_CTRL_POL];

    // Brown-out qualification
    tcfm_pkg::tcfm_ms_t bo_cnt;
    tcfm_pkg::tcfm_ms_t bo_lim;
    logic bo_active;
    logic bo_prev;
    logic power_evt;
    assign bo_lim = ctrl[`TCFM_CTRL_BO] ? `TCFM_BO_ON_MS : BO_OFF_MS;
    assign power_evt = bo_active & ~bo_prev;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            bo_cnt <= '0;
            bo_active <= 1'b0;
            bo_prev <= 1'b0;
        end
        else
        begin
            bo_prev <= bo_active;
            if (ac_ok_s)
            begin
                bo_cnt <= '0;
                bo_active <= 1'b0;
            end
            else
            begin
                bo_cnt <= sat_tick(bo_cnt, bo_lim, tick);
                bo_active <= (bo_cnt >= bo_lim);
            end
        end
    end

    // Red failure timing per channel
    tcfm_pkg::tcfm_ms_t rf_cnt [CHANNELS];
    tcfm_pkg::tcfm_ms_t rf_lim;
    logic rf_mon;
    logic [CHANNELS-1:0] rf_hit;
    // One switch sets the window for every channel
    assign rf_lim = ctrl[`TCFM_CTRL_RFT] ? `TCFM_RF_LONG_MS : `TCFM_RF_SHORT_MS;
    assign rf_mon = red_en_s & ~inhibit & ~rc_active & ~bo_active;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            for (int i = 0; i < CHANNELS; i++)
                rf_cnt[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                if (!rf_mon || !rf_en[i] || red_q[i] || yel_q[i] || grn_q[i])
                    rf_cnt[i] <= '0;
                else
                    rf_cnt[i] <= sat_tick(rf_cnt[i], rf_lim, tick);
            end
        end
    end
    always_comb
    begin
        for (int i = 0; i < CHANNELS; i++)
            rf_hit[i] = (rf_cnt[i] >= rf_lim);
    end

    // Clearance (short or missing yellow) per channel
    tcfm_pkg::tcfm_clr_state_t clr_st [CHANNELS];
    tcfm_pkg::tcfm_ms_t ycnt [CHANNELS];
    logic [CHANNELS-1:0] clr_hit;
    logic clr_mon;
    assign clr_mon = red_en_s & ~rc_active & ~bo_active;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                clr_st[i] <= tcfm_pkg::CLR_IDLE;
                ycnt[i] <= '0;
            end
            clr_hit <= '0;
        end
        else
        begin
            for (int i = 0; i < CHANNELS; i++)
            begin
                clr_hit[i] <= 1'b0;
                if (!clr_mon || !clr_en[i])
                    clr_st[i] <= tcfm_pkg::CLR_IDLE;
                else
                begin
                    case (clr_st[i])
                        tcfm_pkg::CLR_IDLE:
                            if (grn_q[i])
                                clr_st[i] <= tcfm_pkg::CLR_GREEN;
                        tcfm_pkg::CLR_GREEN:
                            if (!grn_q[i])
                                clr_st[i] <= tcfm_pkg::CLR_WAIT;
                        tcfm_pkg::CLR_WAIT:
                        begin
                            ycnt[i] <= '0;
                            if (yel_q[i])
                                clr_st[i] <= tcfm_pkg::CLR_YELLOW;
                            else if (red_q[i])
                            begin
                                clr_hit[i] <= 1'b1;
                                clr_st[i] <= tcfm_pkg::CLR_IDLE;
                            end
                            else if (grn_q[i])
                                clr_st[i] <= tcfm_pkg::CLR_GREEN;
                        end
                        tcfm_pkg::CLR_YELLOW:
                        begin
                            // Qualified time lags the lamp by the on delay
                            ycnt[i] <= sat_tick(ycnt[i], `TCFM_YEL_MIN_MS - `TCFM_FIELD_ON_MS,
                                                tick);
                            if (!yel_q[i])
                            begin
                                clr_hit[i] <= (ycnt[i] < `TCFM_YEL_MIN_MS - `TCFM_FIELD_ON_MS);
                                clr_st[i] <= tcfm_pkg::CLR_IDLE;
                            end
                        end
                        default:
                            clr_st[i] <= tcfm_pkg::CLR_IDLE;
                    endcase
                end
            end
        end
    end

    // Watchdog timing
    tcfm_pkg::tcfm_ms_t wdt_cnt;
    tcfm_pkg::tcfm_ms_t wdt_lim;
    logic wdt_prev;
    logic wdt_hit;
    assign wdt_lim = ctrl[`TCFM_CTRL_WDT] ? `TCFM_WDT_SHORT_MS : `TCFM_WDT_LONG_MS;
    assign wdt_hit = (wdt_cnt >= wdt_lim);
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            wdt_cnt <= '0;
            wdt_prev <= 1'b0;
        end
        else
        begin
            wdt_prev <= wdt_s;
            if (wdt_s != wdt_prev || bo_active)
                wdt_cnt <= '0;
            else
                wdt_cnt <= sat_tick(wdt_cnt, wdt_lim, tick);
        end
    end

    // Latched faults; a new event wins over a clear in the same cycle
    logic any_reset;
    logic flt_red;
    logic flt_clr;
    logic flt_wdt;
    logic flt_cable;
    logic flt_any;
    logic [CHANNELS-1:0] fault_ch;
    assign any_reset = ext_reset_s | cmd_reset;
    assign flt_any = flt_red | flt_clr | flt_wdt | flt_cable;
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            flt_red <= 1'b0;
            flt_clr <= 1'b0;
            flt_wdt <= 1'b0;
            flt_cable <= 1'b0;
            fault_ch <= '0;
        end
        else
        begin
            if (|rf_hit)
                flt_red <= 1'b1;
            else if (any_reset)
                flt_red <= 1'b0;
            if (|clr_hit)
                flt_clr <= 1'b1;
            else if (any_reset)
                flt_clr <= 1'b0;
            if (!cable_s)
                flt_cable <= 1'b1;
            else if (any_reset)
                flt_cable <= 1'b0;
            if (wdt_hit)
                flt_wdt <= 1'b1;
            else if (any_reset || (power_evt && !ctrl[`TCFM_CTRL_RETAIN]))
                flt_wdt <= 1'b0;
            if (any_reset)
                fault_ch <= rf_hit | clr_hit;
            else
                fault_ch <= fault_ch | rf_hit | clr_hit;
        end
    end

    // Indicators follow live state until a trigger, then freeze
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            LED_RED_O <= '0;
            LED_YEL_O <= '0;
            LED_GRN_O <= '0;
            TRIGGERED_O <= 1'b0;
            FLASH_O <= 1'b0;
        end
        else
        begin
            if (!flt_any)
            begin
                LED_RED_O <= red_q;
                LED_YEL_O <= yel_q;
                LED_GRN_O <= grn_q;
            end
            TRIGGERED_O <= flt_any;
            FLASH_O <= flt_any | bo_active;
        end
    end

    // APB slave: zero wait state, answer registered in the setup cycle
    logic setup;
    logic mapped;
    logic [31:0] rdata;
    assign setup = PSEL_I & ~PENABLE_I;
    always_comb
    begin
        mapped = 1'b1;
        rdata = 32'h00000000;
        case (PADDR_I)
            `TCFM_CTRL_OFS:
                rdata = {27'h0000000, ctrl};
            `TCFM_RF_EN_OFS:
                rdata = 32'(rf_en);
            `TCFM_CLR_EN_OFS:
                rdata = 32'(clr_en);
            `TCFM_STATUS_OFS:
                rdata = {24'h000000, rf_mon, rc_active, bo_active, flt_cable, flt_wdt,
                         flt_clr, flt_red, flt_any};
            `TCFM_FAULT_CH_OFS:
                rdata = 32'(fault_ch);
            default:
                mapped = 1'b0;
        endcase
    end
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O <= 32'h00000000;
        end
        else
        begin
            PREADY_O <= setup;
            PSLVERR_O <= setup & ~mapped;
            PRDATA_O <= (setup && !PWRITE_I && mapped) ? rdata : 32'h00000000;
        end
    end
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
        begin
            ctrl <= `TCFM_CTRL_RST;
            rf_en <= `TCFM_RF_EN_RST;
            clr_en <= `TCFM_CLR_EN_RST;
            cmd_reset <= 1'b0;
        end
        else
        begin
            cmd_reset <= 1'b0;
            if (apb_wr && PADDR_I == `TCFM_CTRL_OFS)
            begin
                ctrl <= PWDATA_I[4:0];
                cmd_reset <= PWDATA_I[`TCFM_CTRL_RESET];
            end
            if (apb_wr && PADDR_I == `TCFM_RF_EN_OFS)
                rf_en <= PWDATA_I[CHANNELS-1:0];
            if (apb_wr && PADDR_I == `TCFM_CLR_EN_OFS)
                clr_en <= PWDATA_I[CHANNELS-1:0];
        end
    end

    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!NRST_I);

    sequence s_inhibit_held;
        inhibit ##1 inhibit;
    endsequence
    sequence s_trig_quiet;
        flt_any && !any_reset ##1 flt_any;
    endsequence

    AST_TICK_SPACING: assert property (tick |=> !tick)
        else $error("tick pulses back to back");
    AST_QUAL_OFF: assert property (!pin_s[0] |=> !red_q[0])
        else $error("red stays qualified after input low");
    AST_QUAL_ON: assert property ($rose(grn_q[0]) |-> qcnt[2*CHANNELS] == `TCFM_FIELD_ON_MS)
        else $error("green qualified before on time");
    AST_INH_ON: assert property ($rose(q[NQ-1]) |-> qcnt[NQ-1] == `TCFM_INHIBIT_ON_MS)
        else $error("inhibit active before 550 ms");
    AST_RF_INHIBIT: assert property (s_inhibit_held |-> !$rose(flt_red))
        else $error("red fail raised while inhibited");
    AST_RF_CAUSE: assert property ($rose(flt_red) |-> $past(|rf_hit) && $past(rf_mon, 2))
        else $error("red fail without timed dark channel");
    AST_RF_DISABLED: assert property (!rf_en[1] |=> rf_cnt[1] == 12'h000)
        else $error("disabled channel timing red fail");
    AST_RC_POLARITY: assert property (rc_active |-> ##1 !rf_mon || $changed(rc_active))
        else $error("red monitoring with relay common active");
    AST_CABLE: assert property (!cable_s |=> flt_cable ##1 FLASH_O)
        else $error("cable loss not latched or not flashing");
    AST_TRIG_HOLD: assert property (s_trig_quiet |=> TRIGGERED_O)
        else $error("trigger dropped without reset");
    AST_LED_FREEZE: assert property (flt_any && $past(flt_any) |=> $stable(LED_RED_O))
        else $error("indicators changed while triggered");
    AST_WDT_CLEAR: assert property (power_evt && !ctrl[3] && !wdt_hit |=> !flt_wdt)
        else $error("watchdog fault kept through power event");
    AST_WDT_KEEP: assert property (flt_wdt && ctrl[3] && !any_reset |=> flt_wdt)
        else $error("retained watchdog fault lost");
    AST_APB_READY: assert property (setup |=> PREADY_O)
        else $error("no ready after setup");
endmodule
`default_nettype wire

// ---- logic/tcfm_pkg.sv ----
// Types shared by the fault monitor
`default_nettype none
package tcfm_pkg;
    typedef logic [11:0] tcfm_ms_t;
    typedef enum logic [1:0] {CLR_IDLE, CLR_GREEN, CLR_WAIT, CLR_YELLOW} tcfm_clr_state_t;
endpackage
`default_nettype wire

// ---- logic/tcfm_regs.svh ----
// Register offsets, field positions, reset values and timings of the fault monitor
// Functional notes
// - Red-fail time 1350 ms with timing switch on, 850 ms with it off.
// - Watchdog fault time 1.0 s with switch on, 1.5 s with it off.
// - Brown-out qualified after 400 ms with option on; off value is adjustable.
// - Without retention, a power event clears a latched watchdog fault.
// - With retention, watchdog fault survives power events until a panel, remote or command reset.
// - Relay-common sense follows the input level, inverted when polarity option set.
// - Red interface cable removal latches a fault and forces flashing.
// - Either red-fail inhibit input suppresses only red-failure monitoring.
// - Inhibit input active after 550 ms high; low drops it at once.
// - Red input qualified on after 500 ms high; low drops it at once.
// - Green or yellow qualified on after 500 ms high; low drops it at once.
// - Any fault triggers; trigger holds until panel, remote or command reset, or a power event clears a lone unretained watchdog fault.
// - Dark channel beyond the selected red-fail time triggers a red failure.
// - Dark periods shorter than 350 ms never trigger red failure; the 500 ms on delay of relit red counts as dark.
// - Red-failure checking per channel, only where its enable bit is set.
// - Red-fail monitoring needs permit active, no inhibit, relay common inactive.
// - Yellow missing or shorter than 2.7 s after green raises clearance fault.
// - 54 status indicators: red, yellow, green for each of 18 channels.
// - Indications captured at trigger are held until the monitor is reset.
`ifndef TCFM_REGS_SVH
`define TCFM_REGS_SVH

`define TCFM_CLK_PERIOD_NS 40
`define TCFM_TICK_PERIOD_NS 1000000

`define TCFM_FIELD_ON_MS 12'd500
`define TCFM_INHIBIT_ON_MS 12'd550
`define TCFM_RF_LONG_MS 12'd1350
`define TCFM_RF_SHORT_MS 12'd850
`define TCFM_WDT_SHORT_MS 12'd1000
`define TCFM_WDT_LONG_MS 12'd1500
`define TCFM_BO_ON_MS 12'd400
`define TCFM_BO_OFF_MS_DFLT 12'd400
`define TCFM_YEL_MIN_MS 12'd2700

`define TCFM_CTRL_OFS 12'h000
`define TCFM_RF_EN_OFS 12'h004
`define TCFM_CLR_EN_OFS 12'h008
`define TCFM_STATUS_OFS 12'h00C
`define TCFM_FAULT_CH_OFS 12'h010

`define TCFM_CTRL_RFT 0
`define TCFM_CTRL_WDT 1
`define TCFM_CTRL_BO 2
`define TCFM_CTRL_RETAIN 3
`define TCFM_CTRL_POL 4
`define TCFM_CTRL_RESET 8

`define TCFM_CTRL_RST 5'h00
`define TCFM_RF_EN_RST 18'h3FFFF
`define TCFM_CLR_EN_RST 18'h3FFFF

`endif

// ---- test/tb_top.sv ----
// Self-checking bench for the traffic fault monitor
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int TICK = 10;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [17:0] red;
    logic [17:0] yel;
    logic [17:0] grn;
    logic [17:0] dark = 18'h00000;
    logic [17:0] gon = 18'h00000;
    logic [17:0] yon = 18'h00000;
    logic ac_ok = 1'b1;
    logic [17:0] led_y;
    logic [17:0] led_g;
    logic inh1 = 1'b0;
    logic inh2 = 1'b0;
    logic permit = 1'b0;
    logic relay = 1'b0;
    logic cable = 1'b1;
    logic panel = 1'b0;
    logic remote = 1'b0;
    logic wd;
    logic [17:0] led_r;
    logic trig;
    logic flash;
    logic [31:0] rd;
    logic er;
    int bad_count = 0;
    int check_count = 0;

    always #20 clk = ~clk;

    tcfm_ctrl_model u_ctrl (.clk_i(clk), .nrst_i(nrst), .dark_i(dark), .grn_on_i(gon),
        .yel_on_i(yon), .red_o(red), .yel_o(yel), .grn_o(grn), .wd_o(wd));

    tcfm_monitor #(.TICK_CYCLES(TICK)) u_dut (.REF_CLK_I(clk), .NRST_I(nrst),
        .PADDR_I(paddr), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .RED_I(red), .YEL_I(yel), .GRN_I(grn), .RED_FAIL_INHIBIT1_I(inh1),
        .RED_FAIL_INHIBIT2_I(inh2), .RED_PERMIT_I(permit), .RELAY_COMMON_INPUT_I(relay),
        .RED_INTERFACE_CABLE_I(cable), .AC_OK_I(ac_ok), .WATCHDOG_I(wd),
        .PANEL_RESET_I(panel), .REMOTE_RESET_I(remote), .LED_RED_O(led_r),
        .LED_YEL_O(led_y), .LED_GRN_O(led_g), .TRIGGERED_O(trig), .FLASH_O(flash));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic ms(input int n);
        repeat (n * TICK) @(posedge clk);
    endtask

    task automatic t_regs;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h00000000);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0003FFFF);
        apb(1'b0, 12'h020, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h00000000);
        // Channel 1 red-fail checking off for the rest of the run
        apb(1'b1, 12'h004, 32'h0003FFFD);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h0003FFFD);
    endtask

    task automatic t_qualify;
        @(posedge clk);
        dark <= 18'h3FFFF;
        ms(200);
        chk(led_r, 18'h00000);
        dark <= 18'h00000;
        ms(400);
        chk(led_r, 18'h00000);
        ms(150);
        chk(led_r, 18'h3FFFF);
        chk(trig, 1'b0);
        permit <= 1'b1;
        dark <= 18'h00002;
    endtask

    task automatic t_redfail;
        @(posedge clk);
        dark <= 18'h00003;
        ms(150);
        dark <= 18'h00002;
        ms(600);
        chk(trig, 1'b0);
        inh2 <= 1'b1;
        ms(600);
        dark <= 18'h00003;
        ms(900);
        chk(trig, 1'b0);
        dark <= 18'h00002;
        ms(600);
        inh2 <= 1'b0;
        dark <= 18'h00003;
        inh1 <= 1'b1;
        ms(300);
        inh1 <= 1'b0;
        ms(500);
        chk(trig, 1'b0);
        ms(100);
        chk(trig, 1'b1);
        chk(flash, 1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd & 32'h3F, 32'h03);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h00000001);
        dark <= 18'h00000;
        ms(600);
        chk(led_r, 18'h3FFFC);
        chk(trig, 1'b1);
        remote <= 1'b1;
        ms(1);
        remote <= 1'b0;
        ms(1);
        chk(trig, 1'b0);
        chk(led_r, 18'h3FFFF);
    endtask

    task automatic t_long;
        apb(1'b1, 12'h000, 32'h00000001);
        dark <= 18'h00001;
        ms(700);
        dark <= 18'h00000;
        ms(600);
        chk(trig, 1'b0);
        dark <= 18'h00001;
        ms(1300);
        chk(trig, 1'b0);
        ms(100);
        chk(trig, 1'b1);
        dark <= 18'h00000;
        ms(600);
        panel <= 1'b1;
        ms(1);
        panel <= 1'b0;
        ms(1);
        chk(trig, 1'b0);
    endtask

    task automatic t_cable;
        @(posedge clk);
        cable <= 1'b0;
        repeat (6) @(posedge clk);
        chk(trig, 1'b1);
        chk(flash, 1'b1);
        cable <= 1'b1;
        ms(1);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd & 32'h11, 32'h11);
        apb(1'b1, 12'h000, 32'h00000100);
        ms(1);
        chk(trig, 1'b0);
    endtask

    task automatic t_relay;
        apb(1'b1, 12'h000, 32'h00000010);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd & 32'hC0, 32'h40);
        relay <= 1'b1;
        repeat (4) @(posedge clk);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd & 32'hC0, 32'h80);
        apb(1'b1, 12'h000, 32'h00000000);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd & 32'hC0, 32'h40);
        relay <= 1'b0;
    endtask

    task automatic t_clear;
        @(posedge clk);
        gon <= 18'h00004;
        dark <= 18'h00004;
        ms(550);
        chk(led_g, 18'h00004);
        gon <= 18'h00000;
        yon <= 18'h00004;
        ms(550);
        chk(led_y, 18'h00004);
        chk(trig, 1'b0);
        yon <= 18'h00000;
        dark <= 18'h00000;
        ms(1);
        chk(trig, 1'b1);
        apb(1'b0, 12'h010, 32'h0);
        chk(rd, 32'h00000004);
        panel <= 1'b1;
        ms(1);
        panel <= 1'b0;
        ms(1);
        chk(trig, 1'b0);
    endtask

    task automatic t_bo;
        apb(1'b1, 12'h000, 32'h00000004);
        ac_ok <= 1'b0;
        ms(380);
        chk(flash, 1'b0);
        ms(30);
        chk(flash, 1'b1);
        chk(trig, 1'b0);
        ac_ok <= 1'b1;
        ms(1);
        chk(flash, 1'b0);
    endtask

    task automatic close_out;
        if (bad_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Whole plan is near 100k cycles; margin kept small to stay bounded
    initial
    begin
        #4400000;
        bad_count++;
        close_out();
    end

    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        t_regs();
        t_qualify();
        t_redfail();
        t_long();
        t_cable();
        t_relay();
        t_clear();
        t_bo();
        close_out();
    end
endmodule
`default_nettype wire

// ---- test/tcfm_ctrl_model.sv ----
// Behavioural signal controller: red lamps and watchdog facing the monitor
`timescale 1ns/1ps
`default_nettype none
module tcfm_ctrl_model #(
    parameter int WD_HALF = 2000
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [17:0] dark_i,
    input wire logic [17:0] grn_on_i,
    input wire logic [17:0] yel_on_i,
    output logic [17:0] red_o,
    output logic [17:0] yel_o,
    output logic [17:0] grn_o,
    output logic wd_o
);
    int cnt;
    // Healthy controller keeps its watchdog toggling well inside any limit
    always_ff @(posedge clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            cnt <= 0;
            wd_o <= 1'b0;
        end
        else if (cnt == WD_HALF - 1)
        begin
            cnt <= 0;
            wd_o <= ~wd_o;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
    // Red lit unless dark; green and yellow as the bench asks
    assign red_o = ~dark_i;
    assign yel_o = yel_on_i;
    assign grn_o = grn_on_i;
endmodule
`default_nettype wire
